// file: dpfse_pkg.sv
// Purpose: Shared constants and types for the flash host controller
// Assumes: 100 MHz system clock, asynchronous flash bus with status bits
// Notes: Long counts are defaults for parameters of the top module
package dpfse_pkg;
    // Clock period and bus widths
    localparam int CLK_NS = 10;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int PIN_W = DATA_W + 1;
    // Pin timing in ns
    localparam int T_ACC_NS = 85;
    localparam int T_OEHP_NS = 50;
    localparam int T_SRW_NS = 50;
    localparam int T_WP_NS = 40;
    localparam int T_WPH_NS = 30;
    localparam int T_RP_NS = 500;
    localparam int T_RH_NS = 50;
    // Operation times
    localparam int T_EPS_US = 15;
    localparam int T_BP_MAX_US = 50;
    localparam int T_BPVPP_MAX_US = 25;
    localparam int T_EC_MAX_S = 12;
    localparam int T_ECVPP_MAX_S = 6;
    localparam int T_SEC_MAX_MS = 400;
    // Cycle counts, least times rounded up
    localparam int SYNC_CYC = 3;
    localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_CYC = ACC_CYC + SYNC_CYC + 1;
    localparam int OEHP_CYC = (T_OEHP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SRW_CYC = (T_SRW_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC = (OEHP_CYC > SRW_CYC) ? OEHP_CYC : SRW_CYC;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RH_CYC = (T_RH_NS + CLK_NS - 1) / CLK_NS;
    // Longest times rounded down
    localparam longint DEF_EPS_CYC = longint'(T_EPS_US) * 1000 / CLK_NS;
    localparam longint DEF_BP_CYC = longint'(T_BP_MAX_US) * 1000 / CLK_NS;
    localparam longint DEF_BPVPP_CYC = longint'(T_BPVPP_MAX_US) * 1000 / CLK_NS;
    localparam longint DEF_EC_CYC = longint'(T_EC_MAX_S) * 1000000000 / CLK_NS;
    localparam longint DEF_ECVPP_CYC = longint'(T_ECVPP_MAX_S) * 1000000000 / CLK_NS;
    localparam longint DEF_SEC_CYC = longint'(T_SEC_MAX_MS) * 1000000 / CLK_NS;
    // Status bit positions and command words
    localparam int POLLING_STATUS_BIT = 7;
    localparam int TOGGLE_STATUS_BIT = 6;
    localparam int ERASE_TOGGLE_STATUS_BIT = 2;
    localparam int BUSY_PIN_BIT = 16;
    localparam logic [ADDR_W-1:0] CHIP_ERASE_ADDR = 20'h00555;
    localparam logic [DATA_W-1:0] CHIP_ERASE_DATA = 16'h0010;
    localparam logic [DATA_W-1:0] SECT_ERASE_DATA = 16'h0030;
    localparam int ID_ADDR_BITS = 2;
    // User commands
    typedef enum logic [3:0] {
        OP_READ = 4'h0,
        OP_WRITE = 4'h1,
        OP_PROGRAM = 4'h2,
        OP_CHIP_ERASE = 4'h3,
        OP_SECT_ERASE = 4'h4,
        OP_SUSPEND = 4'h5,
        OP_RESET = 4'h6,
        OP_ID_READ = 4'h7
    } dpfse_op_type;
    // Sequencer states, Gray along the usual path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_RD_LOW = 4'h1,
        ST_RD_HIGH = 4'h3,
        ST_RESP = 4'h2,
        ST_WR_LOW = 4'h6,
        ST_WR_HIGH = 4'h7,
        ST_SUSP_WAIT = 4'h5,
        ST_RST_LOW = 4'h4,
        ST_RST_WAIT = 4'hC
    } dpfse_state_type;
endpackage : dpfse_pkg

// file: dpfse_pin_if.sv
// Purpose: Carries raw and filtered flash pin inputs
// Assumes: Raw bits come from outside the clock domain
// Notes: Bit 16 is the ready/busy pin, bits 15..0 the data bus
`timescale 1ns/10ps
interface dpfse_pin_if #(parameter int W = 17) ();
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport filt (input raw, output clean);
    modport user (output raw, input clean);
endinterface : dpfse_pin_if

// file: dpfse_pin_filter.sv
// Purpose: Three-stage synchroniser with agreement filter per pin
// Assumes: One clock, synchronous active-high reset
// Notes: Clean output moves only when stages two and three agree
`timescale 1ns/10ps
module dpfse_pin_filter #(
    parameter int W = 17
) (
    input wire logic clk_sys,
    input wire logic srst,
    dpfse_pin_if.filt pins
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] clean;
    } dpfse_filt_type;

    dpfse_filt_type r_reg;
    dpfse_filt_type r_next;
    logic [W-1:0] agree;

    // Shift chain; first stage is read only by the second
    always_comb begin
        r_next = r_reg;
        r_next.s1 = pins.raw;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        agree = ~(r_reg.s2 ^ r_reg.s3);
        r_next.clean = (agree & r_reg.s3) | (~agree & r_reg.clean);
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign pins.clean = r_reg.clean;

    a_filter_agree: assert property (@(posedge clk_sys) disable iff (srst)
        (r_reg.s2 == r_reg.s3) |=> (r_reg.clean == $past(r_reg.s3)))
        else $error("filtered pin did not follow agreeing stages");
    a_filter_hold: assert property (@(posedge clk_sys) disable iff (srst)
        (r_reg.s2 != r_reg.s3) |=> (r_reg.clean[0] == $past(r_reg.clean[0]))
            || ($past(r_reg.s2[0]) == $past(r_reg.s3[0])))
        else $error("filtered pin moved while stages disagreed");
endmodule : dpfse_pin_filter

// file: dpfse_host.sv
// Purpose: Host sequencer for a dual-plane flash on an asynchronous bus
// Assumes: Unlock cycles are issued by the user as plain writes
// Notes: Polls toggle status after program and erase, with timeouts
// Notes on behaviour
// - Chip erase final write goes to 555; sector erase to sector address.
// - Final erase data 10H erases chip, 30H erases addressed sector.
// - Output enable stays high while write enable and chip enable are low.
// - Reset held low at least 500 ns, then 50 ns before reading.
// - At least 50 ns from end of read to next write.
// - Toggle reads pulse output enable; high at least 50 ns between.
// - Toggle polling keeps the same address on every read.
// - Only change of bit 6 between reads matters, not its value.
// - Identification reads maker code at 0, part code at 1.
// - Identification cycles use only low data byte and low address bits; the host still returns all 16 bits of din in RSP_DATA.
`timescale 1ns/10ps
module dpfse_host
    import dpfse_pkg::*;
#(
    parameter int unsigned EPS_CYC = 32'(DEF_EPS_CYC),
    parameter int unsigned BP_CYC = 32'(DEF_BP_CYC),
    parameter int unsigned BPVPP_CYC = 32'(DEF_BPVPP_CYC),
    parameter int unsigned EC_CYC = 32'(DEF_EC_CYC),
    parameter int unsigned ECVPP_CYC = 32'(DEF_ECVPP_CYC),
    parameter int unsigned SEC_CYC = 32'(DEF_SEC_CYC),
    parameter logic [DATA_W-1:0] SUSPEND_DATA = 16'h00B0
) (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic CMD_VALID,
    input wire dpfse_op_type CMD_OP,
    input wire logic [ADDR_W-1:0] CMD_ADDR,
    input wire logic [DATA_W-1:0] CMD_DATA,
    input wire logic FAST_VPP,
    output logic CMD_READY,
    output logic RSP_VALID,
    output logic [DATA_W-1:0] RSP_DATA,
    output logic [3:0] RSP_STATUS,
    output logic [ADDR_W-1:0] F_ADDR,
    output logic [DATA_W-1:0] F_DQ_OUT,
    output logic F_DQ_OE,
    input wire logic [DATA_W-1:0] F_DQ_IN,
    output logic F_CE_N,
    output logic F_OE_N,
    output logic F_WE_N,
    output logic F_RESET_N,
    input wire logic F_RDY_BUSY
);
    typedef struct packed {
        dpfse_state_type st;
        dpfse_op_type op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [31:0] cnt;
        logic [31:0] tmo;
        logic [31:0] limit;
        logic polling;
        logic first;
        logic [1:0] prev;
        logic done;
        logic fail;
        logic tmo_hit;
        logic e2_tgl;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
        logic dq_oe;
        logic ready;
        logic rsp_v;
        logic [DATA_W-1:0] rsp_d;
        logic [3:0] rsp_s;
    } dpfse_regs_type;

    dpfse_regs_type r_reg;
    dpfse_regs_type r_next;
    logic [DATA_W-1:0] din;

    dpfse_pin_if #(.W(PIN_W)) pins ();

    dpfse_pin_filter #(.W(PIN_W)) u_filt (
        .clk_sys(CLK_SYS),
        .srst(SRST),
        .pins(pins.filt)
    );

    assign pins.raw = {F_RDY_BUSY, F_DQ_IN};
    assign din = pins.clean[DATA_W-1:0];

    // Sequencer next state
    always_comb begin
        r_next = r_reg;
        r_next.rsp_v = 1'b0;
        if (r_reg.polling) begin
            r_next.tmo = r_reg.tmo + 32'd1;
        end
        unique case (r_reg.st)
            ST_IDLE: begin
                r_next.ready = 1'b1;
                if (CMD_VALID && r_reg.ready) begin
                    r_next.ready = 1'b0;
                    r_next.op = CMD_OP;
                    r_next.addr = CMD_ADDR;
                    r_next.wdata = CMD_DATA;
                    r_next.cnt = 32'd0;
                    r_next.tmo = 32'd0;
                    r_next.polling = 1'b0;
                    r_next.first = 1'b1;
                    r_next.done = 1'b0;
                    r_next.fail = 1'b0;
                    r_next.tmo_hit = 1'b0;
                    r_next.e2_tgl = 1'b0;
                    r_next.st = ST_WR_LOW;
                    r_next.ce_n = 1'b0;
                    r_next.we_n = 1'b0;
                    r_next.dq_oe = 1'b1;
                    unique case (CMD_OP)
                        OP_READ, OP_ID_READ: begin
                            r_next.st = ST_RD_LOW;
                            r_next.we_n = 1'b1;
                            r_next.dq_oe = 1'b0;
                            r_next.oe_n = 1'b0;
                            if (CMD_OP == OP_ID_READ) begin
                                // Upper address bits held low in identification
                                r_next.addr = {{(ADDR_W-ID_ADDR_BITS){1'b0}},
                                    CMD_ADDR[ID_ADDR_BITS-1:0]};
                            end
                        end
                        OP_CHIP_ERASE: begin
                            r_next.addr = CHIP_ERASE_ADDR;
                            r_next.wdata = CHIP_ERASE_DATA;
                            r_next.limit = FAST_VPP ? ECVPP_CYC : EC_CYC;
                        end
                        OP_SECT_ERASE: begin
                            r_next.wdata = SECT_ERASE_DATA;
                            r_next.limit = SEC_CYC;
                        end
                        OP_PROGRAM: begin
                            r_next.limit = FAST_VPP ? BPVPP_CYC : BP_CYC;
                        end
                        OP_SUSPEND: begin
                            r_next.wdata = SUSPEND_DATA;
                        end
                        OP_RESET: begin
                            r_next.st = ST_RST_LOW;
                            r_next.ce_n = 1'b1;
                            r_next.we_n = 1'b1;
                            r_next.dq_oe = 1'b0;
                            r_next.rst_n = 1'b0;
                        end
                        default: begin
                            r_next.limit = 32'd0;
                        end
                    endcase
                end
            end
            ST_RD_LOW: begin
                r_next.cnt = r_reg.cnt + 32'd1;
                if (r_reg.cnt == 32'(RD_CYC - 1)) begin
                    r_next.cnt = 32'd0;
                    r_next.st = ST_RD_HIGH;
                    r_next.ce_n = 1'b1;
                    r_next.oe_n = 1'b1;
                    r_next.rsp_d = din;
                    if (r_reg.polling) begin
                        // Toggle stop is judged by change only
                        r_next.first = 1'b0;
                        r_next.prev = {din[TOGGLE_STATUS_BIT], din[ERASE_TOGGLE_STATUS_BIT]};
                        r_next.done = !r_reg.first
                            && (din[TOGGLE_STATUS_BIT] == r_reg.prev[1]);
                        r_next.e2_tgl = r_reg.e2_tgl || (!r_reg.first
                            && (din[ERASE_TOGGLE_STATUS_BIT] != r_reg.prev[0]));
                        if (r_reg.op == OP_PROGRAM) begin
                            r_next.fail = din[POLLING_STATUS_BIT]
                                != r_reg.wdata[POLLING_STATUS_BIT];
                        end else begin
                            r_next.fail = !din[POLLING_STATUS_BIT];
                        end
                    end
                end
            end
            ST_RD_HIGH: begin
                r_next.cnt = r_reg.cnt + 32'd1;
                if (r_reg.cnt == 32'(GAP_CYC - 1)) begin
                    r_next.cnt = 32'd0;
                    if (!r_reg.polling || r_reg.done) begin
                        r_next.st = ST_RESP;
                    end else if (r_reg.tmo >= r_reg.limit) begin
                        r_next.tmo_hit = 1'b1;
                        r_next.st = ST_RESP;
                    end else begin
                        // Same address again for the next status read
                        r_next.st = ST_RD_LOW;
                        r_next.ce_n = 1'b0;
                        r_next.oe_n = 1'b0;
                    end
                end
            end
            ST_WR_LOW: begin
                r_next.cnt = r_reg.cnt + 32'd1;
                if (r_reg.cnt == 32'(WP_CYC - 1)) begin
                    r_next.cnt = 32'd0;
                    r_next.st = ST_WR_HIGH;
                    r_next.we_n = 1'b1;
                    r_next.ce_n = 1'b1;
                end
            end
            ST_WR_HIGH: begin
                r_next.cnt = r_reg.cnt + 32'd1;
                r_next.dq_oe = 1'b0; // Data held one cycle past the rising edge
                if (r_reg.cnt == 32'(WPH_CYC - 1)) begin
                    r_next.cnt = 32'd0;
                    unique case (r_reg.op)
                        OP_PROGRAM, OP_CHIP_ERASE, OP_SECT_ERASE: begin
                            r_next.polling = 1'b1;
                            r_next.tmo = 32'd0;
                            r_next.st = ST_RD_LOW;
                            r_next.ce_n = 1'b0;
                            r_next.oe_n = 1'b0;
                        end
                        OP_SUSPEND: begin
                            r_next.st = ST_SUSP_WAIT;
                        end
                        default: begin
                            r_next.st = ST_RESP;
                        end
                    endcase
                end
            end
            ST_SUSP_WAIT: begin
                r_next.cnt = r_reg.cnt + 32'd1;
                if (r_reg.cnt == EPS_CYC - 32'd1) begin
                    r_next.cnt = 32'd0;
                    r_next.st = ST_RESP;
                end
            end
            ST_RST_LOW: begin
                r_next.cnt = r_reg.cnt + 32'd1;
                if (r_reg.cnt == 32'(RP_CYC - 1)) begin
                    r_next.cnt = 32'd0;
                    r_next.rst_n = 1'b1;
                    r_next.st = ST_RST_WAIT;
                end
            end
            ST_RST_WAIT: begin
                r_next.cnt = r_reg.cnt + 32'd1;
                if (r_reg.cnt == 32'(RH_CYC - 1)) begin
                    r_next.cnt = 32'd0;
                    r_next.st = ST_RESP;
                end
            end
            ST_RESP: begin
                r_next.rsp_v = 1'b1;
                r_next.rsp_s = {pins.clean[BUSY_PIN_BIT], r_reg.e2_tgl,
                    r_reg.fail & r_reg.done, r_reg.tmo_hit};
                r_next.polling = 1'b0;
                r_next.ready = 1'b1;
                r_next.st = ST_IDLE;
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
            r_reg.ce_n <= 1'b1;
            r_reg.oe_n <= 1'b1;
            r_reg.we_n <= 1'b1;
            r_reg.rst_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state register
    assign CMD_READY = r_reg.ready;
    assign RSP_VALID = r_reg.rsp_v;
    assign RSP_DATA = r_reg.rsp_d;
    assign RSP_STATUS = r_reg.rsp_s;
    assign F_ADDR = r_reg.addr;
    assign F_DQ_OUT = r_reg.wdata;
    assign F_DQ_OE = r_reg.dq_oe;
    assign F_CE_N = r_reg.ce_n;
    assign F_OE_N = r_reg.oe_n;
    assign F_WE_N = r_reg.we_n;
    assign F_RESET_N = r_reg.rst_n;

    // Helper run counters for the checks below
    logic [7:0] oe_hi_run;
    logic [7:0] rst_lo_run;
    logic [7:0] rst_hi_run;
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            oe_hi_run <= 8'hFF;
            rst_lo_run <= 8'h00;
            rst_hi_run <= 8'hFF;
        end else begin
            oe_hi_run <= !F_OE_N ? 8'h00 : (oe_hi_run == 8'hFF ? oe_hi_run : oe_hi_run + 8'h01);
            rst_lo_run <= F_RESET_N ? 8'h00 : rst_lo_run + 8'h01;
            rst_hi_run <= !F_RESET_N ? 8'h00
                : (rst_hi_run == 8'hFF ? rst_hi_run : rst_hi_run + 8'h01);
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    a_oe_during_write: assert property (!F_WE_N |-> F_OE_N)
        else $error("output enable low during write pulse");
    a_chip_erase_word: assert property ((r_reg.op == OP_CHIP_ERASE) && !F_WE_N
        |-> (F_ADDR == CHIP_ERASE_ADDR) && (F_DQ_OUT == CHIP_ERASE_DATA))
        else $error("chip erase final write wrong address or data");
    a_sect_erase_word: assert property ((r_reg.op == OP_SECT_ERASE) && !F_WE_N
        |-> F_DQ_OUT == SECT_ERASE_DATA && F_DQ_OE)
        else $error("sector erase final write wrong data");
    a_reset_width: assert property ($rose(F_RESET_N) |-> rst_lo_run >= 8'(RP_CYC))
        else $error("reset pulse too short");
    a_reset_to_read: assert property ($fell(F_OE_N) |-> rst_hi_run >= 8'(RH_CYC))
        else $error("read started too soon after reset release");
    a_read_to_write: assert property ($fell(F_WE_N) |-> oe_hi_run >= 8'(SRW_CYC))
        else $error("write started too soon after read");
    a_toggle_gap: assert property ($fell(F_OE_N) |-> oe_hi_run >= 8'(OEHP_CYC))
        else $error("output enable high pulse too short between reads");
    a_poll_addr: assert property (r_reg.polling && $past(r_reg.polling)
        |-> $stable(F_ADDR))
        else $error("address moved during status polling");
    a_id_addr: assert property ((r_reg.op == OP_ID_READ) && !F_OE_N
        |-> F_ADDR[ADDR_W-1:ID_ADDR_BITS] == '0)
        else $error("identification read with upper address bits set");
    a_rsp_pulse: assert property (RSP_VALID |=> !RSP_VALID && CMD_READY)
        else $error("response not a single cycle pulse");

    c_chip_erase: cover property ((r_reg.op == OP_CHIP_ERASE) && RSP_VALID);
    c_prog_done: cover property ((r_reg.op == OP_PROGRAM) && RSP_VALID && !RSP_STATUS[0]);
    c_timeout: cover property (RSP_VALID && RSP_STATUS[0]);
    c_reset: cover property ((r_reg.op == OP_RESET) && RSP_VALID);
endmodule : dpfse_host

// file: dpfse_flash_model.sv
// Purpose: Behavioural flash device seen by the host sequencer
// Assumes: Unlock cycles are not checked, bit 19 selects the plane
// Notes: bad counts pin timing faults made by the host
`timescale 1ns/10ps
module dpfse_flash_model
    import dpfse_pkg::*;
#(
    parameter int BUSY_NS = 2000,
    parameter logic [DATA_W-1:0] ID0 = 16'h00A5, // Arbitrary value
    parameter logic [DATA_W-1:0] ID1 = 16'h005A, // Arbitrary value
    parameter logic [DATA_W-1:0] ID3 = 16'h0033 // Arbitrary value
) (
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_w,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic rst_n,
    output logic [DATA_W-1:0] dq_r,
    output logic rdy,
    output int bad
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] val, prg, last;
    logic [7:0] pend;
    logic [3:0] idx;
    logic busy, ers, idm, tog, chip;
    time t_oe, t_rs, t_rh;
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        {busy, ers, idm, tog, pend, bad, last, t_oe, t_rs, t_rh} = '0;
    end
    // Command decode at the end of each write strobe
    always @(posedge we_n) begin
        if (dq_w[7:0] == 8'hF0) idm = 1'b0;
        else if (dq_w[7:0] == 8'h90) idm = 1'b1;
        else if (pend == 8'hA0) run(1'b0);
        else if (pend == 8'h80 && (dq_w[7:0] == 8'h30 || (dq_w[7:0] == 8'h10
            && addr == 20'h00555))) run(1'b1);
        pend = dq_w[7:0];
    end
    // Busy span, then array update
    task automatic run(input logic e);
        {busy, ers, prg, chip, idx} = {1'b1, e, dq_w, dq_w[7:0] == 8'h10, addr[19], addr[2:0]};
        fork
            begin
                #(e ? 2 * BUSY_NS : BUSY_NS);
                foreach (mem[i]) if (!e ? i == idx : chip || i[3] == idx[3]) mem[i] = e ? 16'hFFFF : prg;
                busy = 1'b0;
            end
        join_none
    endtask : run
    // Status or array word chosen at output enable fall
    always @(negedge oe_n) begin
        if ($time - t_oe < 50 || $time - t_rh < 50) bad++;
        tog = ~tog;
        if (busy && addr[19] == idx[3] && !ers && addr[2:0] != idx[2:0]) bad++;
        if (busy && addr[19] == idx[3])
            val = ers ? {9'h1FE, tog, 3'b111, tog, 2'b11}
                : {prg[15:8], ~prg[7], tog, prg[5:3], 1'b1, prg[1:0]};
        else if (idm && addr[19:2] == '0) val = addr[1] ? ID3 : (addr[0] ? ID1 : ID0);
        else val = mem[{addr[19], addr[2:0]}];
    end
    // Released bus shows the inverse of the last word
    always @(posedge oe_n) {t_oe, last} = {$time, val};
    assign dq_r = (!ce_n && !oe_n) ? val : ~last;
    assign rdy = !busy;
    // Write must not overlap a read or follow it too closely
    always @(negedge we_n) #1 if (!oe_n || $time - t_oe < 51) bad++;
    always @(negedge rst_n) t_rs = $time;
    always @(posedge rst_n) begin
        t_rh = $time;
        if (t_rs != 0 && t_rh - t_rs < 500) bad++;
    end
endmodule : dpfse_flash_model

// file: testbench.sv
// Purpose: Self-checking bench for the flash host sequencer
// Assumes: Behavioural flash model on the far side
// Notes: Long operation counts other than ECVPP_CYC are shortened through parameters
`timescale 1ns/10ps
module testbench
    import dpfse_pkg::*;
;
    logic CLK_SYS = 0, SRST = 1, CMD_VALID = 0, FAST_VPP = 0, CMD_READY, RSP_VALID, F_DQ_OE;
    dpfse_op_type CMD_OP = OP_READ;
    logic [ADDR_W-1:0] CMD_ADDR = '0, F_ADDR;
    logic [DATA_W-1:0] CMD_DATA = '0, RSP_DATA, F_DQ_OUT, F_DQ_IN, dq_dev;
    logic [3:0] RSP_STATUS;
    logic F_CE_N, F_OE_N, F_WE_N, F_RESET_N, F_RDY_BUSY;
    int miscompares = 0, compares = 0, bad;
    dpfse_host #(.EPS_CYC(50), .BP_CYC(400), .BPVPP_CYC(100), .EC_CYC(800),
        .SEC_CYC(800)) i_dpfse_host (.CLK_SYS(CLK_SYS), .SRST(SRST), .CMD_VALID(CMD_VALID),
        .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .CMD_DATA(CMD_DATA), .FAST_VPP(FAST_VPP),
        .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
        .RSP_STATUS(RSP_STATUS), .F_ADDR(F_ADDR), .F_DQ_OUT(F_DQ_OUT), .F_DQ_OE(F_DQ_OE),
        .F_DQ_IN(F_DQ_IN), .F_CE_N(F_CE_N), .F_OE_N(F_OE_N), .F_WE_N(F_WE_N),
        .F_RESET_N(F_RESET_N), .F_RDY_BUSY(F_RDY_BUSY));
    dpfse_flash_model i_dpfse_flash_model (.addr(F_ADDR), .dq_w(F_DQ_OUT), .ce_n(F_CE_N),
        .oe_n(F_OE_N), .we_n(F_WE_N), .rst_n(F_RESET_N), .dq_r(dq_dev), .rdy(F_RDY_BUSY),
        .bad(bad));
    // Data wire level from both drivers
    assign F_DQ_IN = F_DQ_OE ? F_DQ_OUT : dq_dev;
    initial forever #5 CLK_SYS = ~CLK_SYS;
    task automatic check(input string name, input logic [DATA_W-1:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // One command, held until taken, then wait for its response
    task automatic cmd(input dpfse_op_type op, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic v);
        int n;
        @(posedge CLK_SYS);
        #1;
        {CMD_VALID, CMD_OP, CMD_ADDR, CMD_DATA, FAST_VPP} = {1'b1, op, a, d, v};
        for (n = 0; n < 100 && CMD_READY !== 1'b1; n++) @(posedge CLK_SYS) #1;
        @(posedge CLK_SYS);
        #1;
        CMD_VALID = 1'b0;
        for (n = 0; n < 5000 && RSP_VALID !== 1'b1; n++) @(posedge CLK_SYS) #1;
    endtask : cmd
    task automatic t_ident();
        cmd(OP_WRITE, 20'h00555, 16'h0090, 1'b0);
        cmd(OP_ID_READ, 20'hABC00, 16'h0000, 1'b0);
        check("maker code", RSP_DATA, 16'h00A5);
        cmd(OP_ID_READ, 20'hABC01, 16'h0000, 1'b0);
        check("part code", RSP_DATA, 16'h005A);
        cmd(OP_ID_READ, 20'hABC03, 16'h0000, 1'b0);
        check("second part code", RSP_DATA, 16'h0033);
        cmd(OP_WRITE, 20'h00555, 16'h00F0, 1'b0);
        cmd(OP_READ, 20'h00000, 16'h0000, 1'b0);
        check("array after exit", RSP_DATA, 16'h0000);
    endtask : t_ident
    task automatic t_program();
        cmd(OP_WRITE, 20'h00555, 16'h00A0, 1'b0);
        cmd(OP_PROGRAM, 20'h00002, 16'h1234, 1'b0);
        check("program status", RSP_STATUS[1:0], 16'h0000);
        cmd(OP_READ, 20'h00002, 16'h0000, 1'b0);
        check("program data", RSP_DATA, 16'h1234);
        cmd(OP_WRITE, 20'h00555, 16'h00A0, 1'b0);
        cmd(OP_PROGRAM, 20'h80003, 16'h00FF, 1'b1);
        check("fast timeout", RSP_STATUS[0], 16'h0001);
        check("busy polling bit", RSP_DATA[7], 16'h0000);
        check("busy erase toggle bit", RSP_DATA[2], 16'h0001);
        cmd(OP_READ, 20'h00002, 16'h0000, 1'b0);
        check("other plane", RSP_DATA, 16'h1234);
        repeat (300) @(posedge CLK_SYS);
        cmd(OP_READ, 20'h80003, 16'h0000, 1'b0);
        check("late program data", RSP_DATA, 16'h00FF);
    endtask : t_program
    task automatic t_erase();
        cmd(OP_WRITE, 20'h00555, 16'h0080, 1'b0);
        cmd(OP_CHIP_ERASE, 20'h12345, 16'h0000, 1'b0);
        check("chip erase status", RSP_STATUS[2:0], 16'h0004);
        cmd(OP_READ, 20'h00002, 16'h0000, 1'b0);
        check("chip erased", RSP_DATA, 16'hFFFF);
        cmd(OP_WRITE, 20'h00555, 16'h00A0, 1'b0);
        cmd(OP_PROGRAM, 20'h80005, 16'h0000, 1'b0);
        cmd(OP_WRITE, 20'h00555, 16'h0080, 1'b0);
        cmd(OP_SECT_ERASE, 20'h80005, 16'h0000, 1'b1);
        check("sector erase status", RSP_STATUS[1:0], 16'h0000);
        cmd(OP_READ, 20'h80005, 16'h0000, 1'b0);
        check("sector erased", RSP_DATA, 16'hFFFF);
    endtask : t_erase
    initial begin
        #1000000;
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge CLK_SYS);
        #1 SRST = 1'b0;
        t_ident();
        t_program();
        t_erase();
        cmd(OP_RESET, 20'h00000, 16'h0000, 1'b0);
        cmd(OP_READ, 20'h00002, 16'h0000, 1'b0);
        check("pin timing faults", 16'(bad), 16'h0000);
        check("ready pin after reset", RSP_STATUS[3], 16'h0001);
        end_of_test();
    end
endmodule : testbench
